// *** ckg_pkg.sv ***
// Package with register map, field layout and carrier types of the clock generator bank.
package ckg_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_CORE = 8'h00;
  localparam logic [7:0] ADDR_FRAC_HI = 8'h01;
  localparam logic [7:0] ADDR_FRAC_LO = 8'h02;
  localparam logic [7:0] ADDR_ROUTE = 8'h03;
  localparam logic [7:0] ADDR_LOCK = 8'h0c;

  localparam int GEN_COUNT = 16;
  localparam int GEN_IDX_W = 4;
  localparam logic [7:0] GEN_ADDR [GEN_COUNT] = '{
    8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b,
    8'h1b, 8'h1c, 8'h20, 8'h21, 8'h92, 8'h93, 8'h94, 8'hee};
  localparam logic [15:0] GEN_RESET [GEN_COUNT] = '{
    16'h0000, 16'h0000, 16'h2aa0, 16'h6503, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] RST_CORE = 16'h0861;
  localparam logic [15:0] RST_FRAC_HI = 16'h5599;
  localparam logic [15:0] RST_FRAC_LO = 16'hc28f;
  localparam logic [15:0] RST_ROUTE = 16'h1801;
  localparam logic [15:0] RST_LOCK = 16'h0000;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int CORE_SMCLK_LSB = 10;
  localparam int CORE_INT_LSB = 3;
  localparam int CORE_FUSE_BIT = 0;
  localparam logic [15:0] CORE_RW_MASK = 16'hfff8;
  localparam logic [15:0] CORE_FUSE_MASK = 16'h0001;
  localparam int FRAC_HI_LSB = 8;
  localparam int ADC_LSB = 0;
  localparam int ROUTE_INT_LSB = 9;
  localparam int ROUTE_B_SRC = 8;
  localparam int ROUTE_B_COMB = 7;
  localparam int ROUTE_B_IDLE = 6;
  localparam int ROUTE_A_IDLE = 5;
  localparam int ROUTE_A_SRC = 4;
  localparam int ROUTE_A_COMB = 3;
  localparam int ROUTE_A_DIV_LSB = 0;
  localparam logic [7:0] LOCK_CODE = 8'h5b;

  // Channel divide code to ratio, zero meaning the divider is off.
  localparam logic [5:0] DIV_RATIO [8] = '{
    6'h00, 6'h02, 6'h04, 6'h06, 6'h08, 6'h0a, 6'h14, 6'h28};

  // ****************************************************************
  // Serial interface constants
  // ****************************************************************
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    CKG_SRC_FIRST = 2'h0,
    CKG_SRC_SECOND = 2'h1,
    CKG_SRC_COMBINER = 2'h2
  } ckg_src_t;

  typedef enum logic [3:0] {
    CKG_IDLE = 4'h0,
    CKG_ADDR = 4'h1,
    CKG_ADDR_ACK = 4'h3,
    CKG_REG = 4'h2,
    CKG_REG_ACK = 4'h6,
    CKG_WR = 4'h7,
    CKG_WR_ACK = 4'h5,
    CKG_RD = 4'h4,
    CKG_RD_ACK = 4'hc
  } ckg_state_t;

  typedef struct packed {
    logic [5:0] state_machine_clock_divide;
    logic [6:0] first_frac_divider_integer;
    logic [23:0] first_frac_divider_numerator;
    logic [7:0] adc_clock_divide;
    logic [6:0] second_frac_divider_integer;
    ckg_src_t channel_a_source;
    ckg_src_t channel_b_source;
    logic [5:0] channel_a_divide_ratio;
    logic channel_a_divider_on;
    logic output_a_idle_drive;
    logic output_b_idle_drive;
    logic fuse_programmed_flag;
    logic locked_write_open;
  } ckg_cfg_t;

endpackage : ckg_pkg

// *** ckg_pin_filter.sv ***
// Three-stage synchroniser with agreement filter for one pin input.
`timescale 1ns/1ps
module ckg_pin_filter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic pin_in,
  output logic level
);

  logic [2:0] sync;

  // ****************************************************************
  // Synchroniser and filter
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync <= 3'h7;
      level <= 1'b1;
    end else if (clk_en) begin
      sync <= {sync[1:0], pin_in};
      if (sync[1] == sync[2]) begin
        level <= sync[2];
      end
    end
  end

endmodule : ckg_pin_filter

// *** ckg_regs.sv ***
// Configuration register bank with its serial configuration slave.
//
// Overview of operation
// - Six-bit state machine clock divide sits in first register bits 15:10.
// - Seven-bit first divider integer ratio in bits 9:3, reset twelve.
// - First register bit 0 flags programmed fuses, locked, reset one.
// - Second register high byte holds numerator top eight bits, reset 0x55.
// - Third register holds numerator low sixteen bits, reset 0xc28f.
// - Fourth register bits 15:9 hold second divider integer ratio, reset twelve.
// - Source bit zero picks first divider, one picks second; bits 8 and 4.
// - Combiner feeds channels only when bits 7 and 3 are both one.
// - Disabled output grounds pins at idle bit zero, floats them at one.
// - Channel a code 0 disables, 1 to 7 divide by 2,4,6,8,10,20,40.
`timescale 1ns/1ps
module ckg_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h68
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] output_active,
  output logic [1:0] output_pin_oe,
  output ckg_pkg::ckg_cfg_t cfg
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic scl_f;
  logic sda_f;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  ckg_pkg::ckg_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic rw;
  logic master_nack;
  logic byte_sel;
  logic [7:0] hi_byte;
  logic [7:0] reg_addr;
  logic wr_valid;
  logic [7:0] wr_addr;
  logic [15:0] wr_data;
  logic [15:0] rd_word;
  logic lock_open;
  logic [15:0] core;
  logic [15:0] frac_hi;
  logic [15:0] frac_lo;
  logic [15:0] route;
  logic [15:0] lock;
  logic [15:0] gen_q [ckg_pkg::GEN_COUNT];

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [7:0] pick_byte(input logic [15:0] word, input logic low);
    pick_byte = low ? word[7:0] : word[15:8];
  endfunction : pick_byte

  function automatic ckg_pkg::ckg_src_t route_src(input logic src, input logic both_comb);
    if (both_comb) begin
      route_src = ckg_pkg::CKG_SRC_COMBINER;
    end else if (src) begin
      route_src = ckg_pkg::CKG_SRC_SECOND;
    end else begin
      route_src = ckg_pkg::CKG_SRC_FIRST;
    end
  endfunction : route_src

  // ****************************************************************
  // Pin inputs
  // ****************************************************************
  ckg_pin_filter u_scl (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_in(scl_in),
    .level(scl_f)
  );

  ckg_pin_filter u_sda (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin_in(sda_in),
    .level(sda_f)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (clk_en) begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;
  assign bus_start = scl_f & scl_d & sda_d & ~sda_f;
  assign bus_stop = scl_f & scl_d & ~sda_d & sda_f;

  // ****************************************************************
  // Serial slave state machine
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ckg_pkg::CKG_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      master_nack <= 1'b0;
      byte_sel <= 1'b0;
      hi_byte <= 8'h00;
      reg_addr <= 8'h00;
      sda_oe <= 1'b0;
      wr_valid <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 16'h0000;
    end else if (clk_en) begin
      wr_valid <= 1'b0;
      if (bus_start) begin
        state <= ckg_pkg::CKG_ADDR;
        bit_cnt <= 4'h0;
        byte_sel <= 1'b0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state <= ckg_pkg::CKG_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ckg_pkg::CKG_ADDR, ckg_pkg::CKG_REG, ckg_pkg::CKG_WR: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == ckg_pkg::BYTE_BITS) begin
              bit_cnt <= 4'h0;
              if (state == ckg_pkg::CKG_ADDR) begin
                if (shreg[7:1] == DEV_ADDR) begin
                  rw <= shreg[0];
                  sda_oe <= 1'b1;
                  state <= ckg_pkg::CKG_ADDR_ACK;
                end else begin
                  state <= ckg_pkg::CKG_IDLE;
                end
              end else if (state == ckg_pkg::CKG_REG) begin
                reg_addr <= shreg;
                byte_sel <= 1'b0;
                sda_oe <= 1'b1;
                state <= ckg_pkg::CKG_REG_ACK;
              end else begin
                sda_oe <= 1'b1;
                state <= ckg_pkg::CKG_WR_ACK;
                byte_sel <= ~byte_sel;
                if (byte_sel) begin
                  wr_valid <= 1'b1;
                  wr_addr <= reg_addr;
                  wr_data <= {hi_byte, shreg};
                  reg_addr <= reg_addr + 8'h01;
                end else begin
                  hi_byte <= shreg;
                end
              end
            end
          end
          ckg_pkg::CKG_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (rw) begin
                tx <= pick_byte(rd_word, byte_sel);
                sda_oe <= ~(byte_sel ? rd_word[7] : rd_word[15]);
                state <= ckg_pkg::CKG_RD;
              end else begin
                sda_oe <= 1'b0;
                state <= ckg_pkg::CKG_REG;
              end
            end
          end
          ckg_pkg::CKG_REG_ACK, ckg_pkg::CKG_WR_ACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              state <= ckg_pkg::CKG_WR;
            end
          end
          ckg_pkg::CKG_RD: begin
            if (scl_fall) begin
              if (bit_cnt == ckg_pkg::LAST_BIT) begin
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
                state <= ckg_pkg::CKG_RD_ACK;
              end else begin
                bit_cnt <= bit_cnt + 4'h1;
                tx <= {tx[6:0], 1'b0};
                sda_oe <= ~tx[6];
              end
            end
          end
          ckg_pkg::CKG_RD_ACK: begin
            if (scl_rise) begin
              master_nack <= sda_f;
              if (!sda_f) begin
                byte_sel <= ~byte_sel;
                if (byte_sel) begin
                  reg_addr <= reg_addr + 8'h01;
                end
              end
            end else if (scl_fall) begin
              if (master_nack) begin
                state <= ckg_pkg::CKG_IDLE;
              end else begin
                tx <= pick_byte(rd_word, byte_sel);
                sda_oe <= ~(byte_sel ? rd_word[7] : rd_word[15]);
                state <= ckg_pkg::CKG_RD;
              end
            end
          end
          default: begin
            state <= ckg_pkg::CKG_IDLE;
          end
        endcase
      end
    end
  end

  // The pin is only ever pulled low; the enable carries the data.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
    end else if (clk_en) begin
      sda_out <= 1'b0;
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  // Unlock code check.
  assign lock_open = (lock[7:0] == ckg_pkg::LOCK_CODE);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core <= ckg_pkg::RST_CORE;
    end else if (clk_en && wr_valid && wr_addr == ckg_pkg::ADDR_CORE) begin
      core <= (wr_data & ckg_pkg::CORE_RW_MASK) |
              ((lock_open ? wr_data : core) & ckg_pkg::CORE_FUSE_MASK);
    end
  end

  // Numerator high byte and ADC clock.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frac_hi <= ckg_pkg::RST_FRAC_HI;
    end else if (clk_en && wr_valid && wr_addr == ckg_pkg::ADDR_FRAC_HI) begin
      frac_hi <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frac_lo <= ckg_pkg::RST_FRAC_LO;
    end else if (clk_en && wr_valid && wr_addr == ckg_pkg::ADDR_FRAC_LO) begin
      frac_lo <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      route <= ckg_pkg::RST_ROUTE;
    end else if (clk_en && wr_valid && wr_addr == ckg_pkg::ADDR_ROUTE) begin
      route <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock <= ckg_pkg::RST_LOCK;
    end else if (clk_en && wr_valid && wr_addr == ckg_pkg::ADDR_LOCK) begin
      lock <= wr_data;
    end
  end

  // Plain storage for the remaining mapped entries.
  for (genvar i = 0; i < ckg_pkg::GEN_COUNT; i++) begin : g_gen
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        gen_q[i] <= ckg_pkg::GEN_RESET[i];
      end else if (clk_en && wr_valid && wr_addr == ckg_pkg::GEN_ADDR[i]) begin
        gen_q[i] <= wr_data;
      end
    end
  end

  always_comb begin
    rd_word = 16'h0000;
    case (reg_addr)
      ckg_pkg::ADDR_CORE: rd_word = core;
      ckg_pkg::ADDR_FRAC_HI: rd_word = frac_hi;
      ckg_pkg::ADDR_FRAC_LO: rd_word = frac_lo;
      ckg_pkg::ADDR_ROUTE: rd_word = route;
      ckg_pkg::ADDR_LOCK: rd_word = lock;
      default: begin
        for (int j = 0; j < ckg_pkg::GEN_COUNT; j++) begin
          if (reg_addr == ckg_pkg::GEN_ADDR[j]) begin
            rd_word = gen_q[j];
          end
        end
      end
    endcase
  end

  // ****************************************************************
  // Decoded configuration
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg <= '0;
    end else if (clk_en) begin
      cfg.state_machine_clock_divide <= core[ckg_pkg::CORE_SMCLK_LSB +: 6];
      cfg.first_frac_divider_integer <= core[ckg_pkg::CORE_INT_LSB +: 7];
      cfg.first_frac_divider_numerator <= {frac_hi[ckg_pkg::FRAC_HI_LSB +: 8], frac_lo};
      cfg.adc_clock_divide <= frac_hi[ckg_pkg::ADC_LSB +: 8];
      cfg.second_frac_divider_integer <= route[ckg_pkg::ROUTE_INT_LSB +: 7];
      cfg.channel_a_source <= route_src(route[ckg_pkg::ROUTE_A_SRC],
        route[ckg_pkg::ROUTE_A_COMB] & route[ckg_pkg::ROUTE_B_COMB]);
      cfg.channel_b_source <= route_src(route[ckg_pkg::ROUTE_B_SRC],
        route[ckg_pkg::ROUTE_A_COMB] & route[ckg_pkg::ROUTE_B_COMB]);
      cfg.channel_a_divide_ratio <= ckg_pkg::DIV_RATIO[route[ckg_pkg::ROUTE_A_DIV_LSB +: 3]];
      cfg.channel_a_divider_on <= (route[ckg_pkg::ROUTE_A_DIV_LSB +: 3] != 3'h0);
      cfg.output_a_idle_drive <= route[ckg_pkg::ROUTE_A_IDLE];
      cfg.output_b_idle_drive <= route[ckg_pkg::ROUTE_B_IDLE];
      cfg.fuse_programmed_flag <= core[ckg_pkg::CORE_FUSE_BIT];
      cfg.locked_write_open <= lock_open;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      output_pin_oe <= 2'h0;
    end else if (clk_en) begin
      output_pin_oe[0] <= output_active[0] | ~route[ckg_pkg::ROUTE_A_IDLE];
      output_pin_oe[1] <= output_active[1] | ~route[ckg_pkg::ROUTE_B_IDLE];
    end
  end

endmodule : ckg_regs

// *** ckg_regs_assertions.sv ***
// Concurrent checks on the ports of the clock generator register bank.
`timescale 1ns/1ps
module ckg_regs_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [1:0] output_active,
  input wire logic [1:0] output_pin_oe,
  input wire ckg_pkg::ckg_cfg_t cfg
);
  logic sda_oe_d;
  logic [7:0] since_ack;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_oe_d <= 1'b0;
    end else if (clk_en) begin
      sda_oe_d <= sda_oe;
    end
  end
  // Counts enabled cycles since the data pin was last pulled low.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      since_ack <= 8'hff;
    end else if (clk_en && sda_oe && !sda_oe_d) begin
      since_ack <= 8'h00;
    end else if (clk_en && since_ack != 8'hff) begin
      since_ack <= since_ack + 8'h01;
    end
  end
  sequence settled_sq;
    $past(rst_n, 2) && $past(rst_n) && $past(clk_en);
  endsequence
  sequence released_sq;
    $rose(rst_n) ##0 clk_en;
  endsequence
  pin_drive_a: assert property (settled_sq |-> output_pin_oe ==
    ($past(output_active) | ~{cfg.output_b_idle_drive, cfg.output_a_idle_drive}))
    else $error("output pin drive does not follow activity and idle drive");
  fuse_lock_a: assert property (settled_sq ##0 $changed(cfg.fuse_programmed_flag)
    |-> $past(cfg.locked_write_open)) else $error("fuse flag changed while locked");
  divider_on_a: assert property (cfg.channel_a_divider_on ==
    (cfg.channel_a_divide_ratio != 6'h00)) else $error("divider on flag disagrees with ratio");
  ratio_legal_a: assert property (cfg.channel_a_divide_ratio inside
    {6'h00, 6'h02, 6'h04, 6'h06, 6'h08, 6'h0a, 6'h14, 6'h28}) else $error("illegal ratio");
  combiner_pair_a: assert property ((cfg.channel_a_source == ckg_pkg::CKG_SRC_COMBINER) ==
    (cfg.channel_b_source == ckg_pkg::CKG_SRC_COMBINER)) else $error("combiner on one channel");
  cfg_write_only_a: assert property (settled_sq ##0 $changed(cfg) |->
    since_ack <= 8'h04) else $error("configuration changed without a write");
  reset_ratio_a: assert property (released_sq |=> cfg.first_frac_divider_integer == 7'h0c
    && cfg.second_frac_divider_integer == 7'h0c && cfg.state_machine_clock_divide == 6'h02)
    else $error("integer ratios wrong after reset");
  reset_frac_a: assert property (released_sq |=>
    cfg.first_frac_divider_numerator == 24'h55c28f && cfg.adc_clock_divide == 8'h99
    && cfg.fuse_programmed_flag && cfg.channel_a_divide_ratio == 6'h02)
    else $error("fraction or flags wrong after reset");
endmodule : ckg_regs_assertions

bind ckg_regs ckg_regs_assertions i_chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .output_active(output_active), .output_pin_oe(output_pin_oe), .cfg(cfg));

// *** ckg_host_model.sv ***
// Serial configuration host that drives the bank's clock and data pins.
`timescale 1ns/1ps
module ckg_host_model (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull,
  output logic rd_valid,
  output logic [15:0] rd_word
);
  localparam int HALF = 12;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    rd_valid = 1'b0;
    rd_word = 16'h0000;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic start_cond;
    sda_pull <= 1'b0;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_pull <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
    tick(HALF);
  endtask : start_cond
  task automatic stop_cond;
    sda_pull <= 1'b1;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_pull <= 1'b0;
    tick(HALF);
  endtask : stop_cond
  // Data only moves while the clock is low, held two cycles past the fall.
  task automatic bit_io(input logic b, output logic seen);
    sda_pull <= ~b;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    seen = sda_line;
    scl <= 1'b0;
    tick(2);
  endtask : bit_io
  task automatic send_byte(input logic [7:0] val, output logic acked);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bit_io(val[i], seen);
    end
    bit_io(1'b1, seen);
    acked = !seen;
  endtask : send_byte
  task automatic recv_byte(input logic more, output logic [7:0] val);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, seen);
      val[i] = seen;
    end
    bit_io(!more, seen);
  endtask : recv_byte
  task automatic write_word(input logic [6:0] dev, input logic [7:0] addr,
    input logic [15:0] data, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    logic a3;
    start_cond();
    send_byte({dev, 1'b0}, a0);
    send_byte(addr, a1);
    send_byte(data[15:8], a2);
    send_byte(data[7:0], a3);
    stop_cond();
    ok = a0 & a1 & a2 & a3;
  endtask : write_word
  task automatic read_word(input logic [7:0] addr);
    logic a;
    logic [7:0] hi;
    logic [7:0] lo;
    start_cond();
    send_byte(8'hd0, a);
    send_byte(addr, a);
    start_cond();
    send_byte(8'hd1, a);
    recv_byte(1'b1, hi);
    recv_byte(1'b0, lo);
    stop_cond();
    rd_word <= {hi, lo};
    rd_valid <= 1'b1;
    tick(1);
    rd_valid <= 1'b0;
  endtask : read_word
endmodule : ckg_host_model

// *** ckg_regs_test.sv ***
// Self-checking testbench of the clock generator register bank.
`timescale 1ns/1ps
module ckg_regs_test;
  logic clk;
  logic rst_n;
  logic clk_en;
  logic [1:0] output_active;
  logic sda_line;
  logic scl;
  logic sda_pull;
  logic rd_valid;
  logic [15:0] rd_word;
  logic sda_out;
  logic sda_oe;
  logic [1:0] output_pin_oe;
  ckg_pkg::ckg_cfg_t cfg;
  logic [15:0] exp_q[$];
  int fails;
  int checks_done;
  logic [5:0] ratio_tab [8] = '{6'h00, 6'h02, 6'h04, 6'h06, 6'h08, 6'h0a, 6'h14, 6'h28};
  assign sda_line = (sda_oe ? sda_out : 1'b1) & !sda_pull;
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  ckg_regs i_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .output_active(output_active),
    .output_pin_oe(output_pin_oe), .cfg(cfg));
  ckg_host_model i_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull),
    .rd_valid(rd_valid), .rd_word(rd_word));
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check16
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic expect_reg(input logic [7:0] addr, input logic [15:0] exp);
    exp_q.push_back(exp);
    i_host.read_word(addr);
  endtask : expect_reg
  task automatic put_reg(input logic [6:0] dev, input logic [7:0] addr,
    input logic [15:0] data, input logic ack_exp);
    logic ok;
    i_host.write_word(dev, addr, data, ok);
    check16({15'h0000, ok}, {15'h0000, ack_exp});
  endtask : put_reg
  // Compares each read word against the oldest expectation.
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      check16(rd_word, (exp_q.size() != 0) ? exp_q.pop_front() : 16'hxxxx);
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
  initial begin
    logic [15:0] w;
    logic [15:0] r;
    logic [1:0] eoe;
    fails = 0;
    checks_done = 0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    output_active = 2'b00;
    void'($urandom(32'he7074eee));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    expect_reg(ckg_pkg::ADDR_CORE, 16'h0861);
    expect_reg(ckg_pkg::ADDR_FRAC_HI, 16'h5599);
    expect_reg(ckg_pkg::ADDR_FRAC_LO, 16'hc28f);
    expect_reg(ckg_pkg::ADDR_ROUTE, 16'h1801);
    for (int i = 0; i < ckg_pkg::GEN_COUNT; i++) begin
      expect_reg(ckg_pkg::GEN_ADDR[i], ckg_pkg::GEN_RESET[i]);
    end
    expect_reg(8'h10, 16'h0000);
    put_reg(7'h68, ckg_pkg::ADDR_CORE, 16'h2460, 1'b1);
    expect_reg(ckg_pkg::ADDR_CORE, 16'h2461);
    check16({10'h000, cfg.state_machine_clock_divide}, 16'h0009);
    put_reg(7'h68, ckg_pkg::ADDR_LOCK, 16'h005b, 1'b1);
    put_reg(7'h68, ckg_pkg::ADDR_CORE, 16'h0a68, 1'b1);
    expect_reg(ckg_pkg::ADDR_CORE, 16'h0a68);
    check16({9'h000, cfg.first_frac_divider_integer}, 16'h004d);
    put_reg(7'h68, ckg_pkg::ADDR_LOCK, 16'h0000, 1'b1);
    put_reg(7'h68, ckg_pkg::ADDR_CORE, 16'h0a69, 1'b1);
    expect_reg(ckg_pkg::ADDR_CORE, 16'h0a68);
    w = 16'($urandom());
    r = 16'($urandom());
    put_reg(7'h68, ckg_pkg::ADDR_FRAC_HI, {w[15:8], 8'h99}, 1'b1);
    put_reg(7'h68, ckg_pkg::ADDR_FRAC_LO, r, 1'b1);
    expect_reg(ckg_pkg::ADDR_FRAC_HI, {w[15:8], 8'h99});
    check16({8'h00, cfg.first_frac_divider_numerator[23:16]}, {8'h00, w[15:8]});
    check16(cfg.first_frac_divider_numerator[15:0], r);
    for (int c = 0; c < 8; c++) begin
      w = {13'($urandom()), 3'(c)};
      w[7] = (c >= 6) ? 1'b1 : w[7];
      w[3] = (c == 6) ? 1'b1 : w[3];
      put_reg(7'h68, ckg_pkg::ADDR_ROUTE, w, 1'b1);
      output_active <= 2'($urandom());
      repeat (3) @(posedge clk);
      eoe = output_active | ~{w[6], w[5]};
      check16({10'h000, cfg.channel_a_divide_ratio}, {10'h000, ratio_tab[c]});
      check16({14'h0000, cfg.channel_a_source}, (w[7] && w[3]) ? 16'h2 : {15'h0, w[4]});
      check16({14'h0000, cfg.channel_b_source}, (w[7] && w[3]) ? 16'h2 : {15'h0, w[8]});
      check16({9'h000, cfg.second_frac_divider_integer}, {9'h000, w[15:9]});
      check16({14'h0000, output_pin_oe}, {14'h0000, eoe});
    end
    clk_en <= 1'b0;
    output_active <= ~output_active;
    repeat (10) @(posedge clk);
    check16({14'h0000, output_pin_oe}, {14'h0000, eoe});
    clk_en <= 1'b1;
    repeat (3) @(posedge clk);
    check16({14'h0000, output_pin_oe}, {14'h0000, output_active | ~{w[6], w[5]}});
    put_reg(7'h69, ckg_pkg::ADDR_ROUTE, ~w, 1'b0);
    expect_reg(ckg_pkg::ADDR_ROUTE, w);
    repeat (4) @(posedge clk);
    check16(16'(exp_q.size()), 16'h0000);
    tally_and_finish();
  end
endmodule : ckg_regs_test
